// >>> verilog/rpd_pkg.sv
package rpd_pkg;
    localparam int NW = 8;
    localparam int MW = 20;
    localparam int FW = 21;
    localparam int PW = 4;
    localparam int IW = 6;
    localparam logic [3:0] SEL_ALL_ONES = 4'hF;
    localparam logic [3:0] Y_FIRST_FIVE = 4'hB;
    localparam logic [PW-1:0] DIV_LO_SIX = 4'h6;
    localparam logic [PW-1:0] DIV_LO_FIVE = 4'h5;
    localparam logic [PW-1:0] DIV_HI_ONE = 4'h1;
    localparam logic [PW-1:0] SECOND_DIV_RESET = 4'h1;
    localparam logic [IW-1:0] IN_DIV_MIN = 6'h01;
    localparam logic [IW-1:0] IN_DIV_MAX = 6'h3F;
    localparam logic [IW-1:0] SDM_MIN_INT = 6'h04;
    localparam logic [1:0] XTAL_49152 = 2'h0;
    localparam logic [1:0] XTAL_49860 = 2'h1;
    localparam logic [1:0] XTAL_50000 = 2'h2;
    localparam logic [1:0] XTAL_52000 = 2'h3;
    localparam logic [1:0] RATIO_1 = 2'h0;
    localparam logic [1:0] RATIO_2 = 2'h1;
    localparam logic [1:0] RATIO_4 = 2'h2;
    localparam logic [15:0] PRBS_SEED = 16'hACE1;
    localparam logic [MW-1:0] PRESET_MOD_RESET = 20'h00001;
endpackage

// >>> verilog/rpd_out_preset.sv
`timescale 1ns/1ns
`default_nettype none
module rpd_out_preset
    import rpd_pkg::*;
(
    input wire logic [3:0] sel, // Output rate select strap
    output logic [NW-1:0] n_int, // Feedback integer part
    output logic [MW-1:0] n_mod, // Feedback modulus
    output logic [MW-1:0] n_frac, // Feedback fraction
    output logic [PW-1:0] div_lo, // First output low divider
    output logic [PW-1:0] div_hi // First output high divider
);
    logic [47:0] row;
    always_comb begin
        unique case (sel)
            4'h0: row = {8'd143, 20'd520000, 20'd289600};
            4'h1: row = {8'd144, 20'd520000, 20'd120000};
            4'h2: row = {8'd144, 20'd308100, 20'd236736};
            4'h3: row = {8'd148, 20'd520000, 20'd22400};
            4'h4: row = {8'd148, 20'd465920, 20'd343840};
            4'h5: row = {8'd151, 20'd520000, 20'd370625};
            4'h6: row = {8'd152, 20'd465920, 20'd163160};
            4'h7: row = {8'd153, 20'd465920, 20'd377856};
            4'h8: row = {8'd154, 20'd328640, 20'd151168};
            4'h9: row = {8'd154, 20'd460096, 20'd245216};
            4'hA: row = {8'd155, 20'd490880, 20'd56192};
            4'hB: row = {8'd133, 20'd328640, 20'd119005};
            4'hC: row = {8'd133, 20'd470080, 20'd433856};
            4'hD: row = {8'd135, 20'd349440, 20'd159975};
            4'hE: row = {8'd136, 20'd394368, 20'd11577};
            4'hF: row = {8'd149, 20'd520000, 20'd280000};
        endcase
    end
    assign n_int = row[47:40];
    assign n_mod = row[39:20];
    assign n_frac = row[19:0];
    assign div_lo = (sel < Y_FIRST_FIVE) ? DIV_LO_SIX : DIV_LO_FIVE;
    assign div_hi = DIV_HI_ONE;
endmodule // rpd_out_preset
`default_nettype wire

// >>> verilog/rpd_in_preset.sv
`timescale 1ns/1ns
`default_nettype none
module rpd_in_preset
    import rpd_pkg::*;
(
    input wire logic [3:0] sel, // Reference rate select strap
    output logic [IW-1:0] n_int, // Input divider integer part
    output logic [MW-1:0] n_mod, // Input modulator modulus
    output logic signed [FW-1:0] n_frac // Input modulator signed fraction
);
    logic [46:0] row;
    always_comb begin
        unique case (sel)
            4'h0: row = {6'd23, 20'd130000, 21'sd110800};
            4'h1: row = {6'd24, 20'd130000, -21'sd120000};
            4'h2: row = {6'd24, 20'd154050, -21'sd114594};
            4'h3: row = {6'd24, 20'd130000, 21'sd45200};
            4'h4: row = {6'd24, 20'd166400, 21'sd96400};
            4'h5: row = {6'd25, 20'd104000, -21'sd44625};
            4'h6: row = {6'd25, 20'd198016, -21'sd42891};
            4'h7: row = {6'd25, 20'd154700, 21'sd41820};
            4'h8: row = {6'd25, 20'd154050, 21'sd74970};
            4'h9: row = {6'd25, 20'd182000, 21'sd93000};
            4'hA: row = {6'd25, 20'd153400, 21'sd108120};
            4'hB: row = {6'd26, 20'd197184, 21'sd67998};
            4'hC: row = {6'd26, 20'd146900, 21'sd83612};
            4'hD: row = {6'd27, 20'd198016, -21'sd161755};
            4'hE: row = {6'd27, 20'd197184, -21'sd115995};
            4'hF: row = {6'd1, 20'd1, 21'sd0};
        endcase
    end
    assign n_int = row[46:41];
    assign n_mod = row[40:21];
    assign n_frac = row[20:0];
endmodule // rpd_in_preset
`default_nettype wire

// >>> verilog/rpd_top.sv
`timescale 1ns/1ns
`default_nettype none
//Contract
// - Output select pins decode feedback and first-output presets.
// - Sixteen-entry table; codes 0-10 use 6/1, else 5/1.
// - Second output divider resets to one, host-changed only.
// - Either reference select all ones enters slow mode.
// - Straps alone set all dividers but the second output one without host.
// - Strap values are defaults; host writes override.
// - Slow mode two-bit crystal frequency select.
// - Slow mode input ratios 1, 2, 4 only.
// - Output dividers stay programmable in slow mode.
// - Integer input divider per reference, 1 to 63.
// - Optional second-order modulator per input divider.
// - Divide N plus half plus F over 2M.
// - Modulator enabled needs integer part at least four.
// - Dither on after reset, stops on disable bit.
// - Slow mode disables both input modulators.
// - Grounded pin reads zero, open pin reads one.
// - Each reference's pins set its own presets.
module rpd_top
    import rpd_pkg::*;
(
    input wire logic CLK, // System clock
    input wire logic RESETN, // Asynchronous reset, active low
    input wire logic [3:0] A_SEL, // First reference rate strap
    input wire logic [3:0] B_SEL, // Second reference rate strap
    input wire logic [3:0] Y_SEL, // Output rate strap
    input wire logic WR_OUT_FB, // Write feedback divider set
    input wire logic [rpd_pkg::NW-1:0] WR_FB_INT, // Feedback integer value
    input wire logic [rpd_pkg::MW-1:0] WR_FB_MOD, // Feedback modulus value
    input wire logic [rpd_pkg::MW-1:0] WR_FB_FRAC, // Feedback fraction value
    input wire logic WR_OUT_DIV, // Write output dividers
    input wire logic [rpd_pkg::PW-1:0] WR_DIV_LO, // First output low divider
    input wire logic [rpd_pkg::PW-1:0] WR_DIV_HI, // First output high divider
    input wire logic [rpd_pkg::PW-1:0] WR_DIV_2, // Second output divider
    input wire logic WR_IN_A, // Write first reference divider set
    input wire logic WR_IN_B, // Write second reference divider set
    input wire logic [rpd_pkg::IW-1:0] WR_IN_INT, // Input integer value
    input wire logic [rpd_pkg::MW-1:0] WR_IN_MOD, // Input modulus value
    input wire logic signed [rpd_pkg::FW-1:0] WR_IN_FRAC, // Input signed fraction
    input wire logic WR_IN_SDM_EN, // Input modulator enable value
    input wire logic WR_CFG, // Write mode configuration
    input wire logic [1:0] WR_XTAL_SEL, // Crystal select value
    input wire logic [1:0] WR_RATIO_SEL, // Slow mode ratio value
    input wire logic WR_DITHER_OFF, // Dither disable value
    output logic SLOW_MODE, // Reference-rate special mode active
    output logic [rpd_pkg::NW-1:0] FB_INT, // Feedback integer part
    output logic [rpd_pkg::MW-1:0] FB_MOD, // Feedback modulus
    output logic [rpd_pkg::MW-1:0] FB_FRAC, // Feedback fraction
    output logic [rpd_pkg::PW-1:0] DIV_LO, // First output low divider
    output logic [rpd_pkg::PW-1:0] DIV_HI, // First output high divider
    output logic [rpd_pkg::PW-1:0] DIV_2, // Second output divider
    output logic [1:0] XTAL_SEL, // Assumed crystal select
    output logic [rpd_pkg::IW-1:0] A_INT, // First reference integer ratio
    output logic [rpd_pkg::MW-1:0] A_MOD, // First reference modulus
    output logic signed [rpd_pkg::FW-1:0] A_FRAC, // First reference fraction
    output logic A_SDM_ON, // First reference modulator active
    output logic [rpd_pkg::IW-1:0] B_INT, // Second reference integer ratio
    output logic [rpd_pkg::MW-1:0] B_MOD, // Second reference modulus
    output logic signed [rpd_pkg::FW-1:0] B_FRAC, // Second reference fraction
    output logic B_SDM_ON, // Second reference modulator active
    output logic A_DIV_PULSE, // First reference divider step
    output logic B_DIV_PULSE, // Second reference divider step
    output logic DITHER_ON, // Dither active
    output logic DITHER_BIT // Dither sequence bit
);
    import rpd_pkg::*;

    typedef enum logic [1:0] {
        RPD_LOAD = 2'b01,
        RPD_RUN = 2'b10
    } rpd_state_t;

    function automatic logic [IW-1:0] ratio_value(input logic [1:0] code);
        case (code)
            RATIO_2: ratio_value = 6'h02;
            RATIO_4: ratio_value = 6'h04;
            default: ratio_value = 6'h01;
        endcase
    endfunction

    function automatic logic [IW-1:0] clamp_int(input logic [IW-1:0] v, input logic sdm);
        logic [IW-1:0] lo;
        lo = sdm ? SDM_MIN_INT : IN_DIV_MIN;
        clamp_int = (v < lo) ? lo : v;
    endfunction

    function automatic logic signed [FW-1:0] clamp_frac(input logic signed [FW-1:0] f, input logic [MW-1:0] m);
        logic signed [FW:0] lim;
        lim = $signed({2'b00, m}) - 22'sd1;
        if ($signed({f[FW-1], f}) > lim)
            clamp_frac = lim[FW-1:0];
        else if ($signed({f[FW-1], f}) < -lim)
            clamp_frac = -lim[FW-1:0];
        else
            clamp_frac = f;
    endfunction

    rpd_state_t state_r, state_nxt;
    logic [NW-1:0] yp_int;
    logic [MW-1:0] yp_mod, yp_frac;
    logic [PW-1:0] yp_lo, yp_hi;
    logic [IW-1:0] ap_int, bp_int;
    logic [MW-1:0] ap_mod, bp_mod;
    logic signed [FW-1:0] ap_frac, bp_frac;

    rpd_out_preset u_out (
        .sel(Y_SEL),
        .n_int(yp_int),
        .n_mod(yp_mod),
        .n_frac(yp_frac),
        .div_lo(yp_lo),
        .div_hi(yp_hi)
    );
    rpd_in_preset u_ina (
        .sel(A_SEL),
        .n_int(ap_int),
        .n_mod(ap_mod),
        .n_frac(ap_frac)
    );
    rpd_in_preset u_inb (
        .sel(B_SEL),
        .n_int(bp_int),
        .n_mod(bp_mod),
        .n_frac(bp_frac)
    );

    wire slow_w = (A_SEL == SEL_ALL_ONES) || (B_SEL == SEL_ALL_ONES);
    wire loading = (state_r == RPD_LOAD);
    logic [1:0] ratio_r;
    logic a_sdm_r, b_sdm_r;
    logic [IW-1:0] a_int_r, b_int_r;
    wire [IW-1:0] slow_ratio = ratio_value(ratio_r);
    wire [IW-1:0] wr_in_int_c = clamp_int(WR_IN_INT, WR_IN_SDM_EN);
    wire signed [FW-1:0] wr_in_frac_c = clamp_frac(WR_IN_FRAC, WR_IN_MOD);
    wire [IW-1:0] a_eff = slow_w ? slow_ratio : a_int_r;
    wire [IW-1:0] b_eff = slow_w ? slow_ratio : b_int_r;

    assign state_nxt = RPD_RUN;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN)
            state_r <= RPD_LOAD;
        else
            state_r <= state_nxt;
    end

    // Straps are captured in the first clocked cycle after reset, never by the reset itself.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            FB_INT <= '0;
            FB_MOD <= PRESET_MOD_RESET;
            FB_FRAC <= '0;
            DIV_LO <= DIV_HI_ONE;
            DIV_HI <= DIV_HI_ONE;
            DIV_2 <= SECOND_DIV_RESET;
        end else if (loading) begin
            FB_INT <= yp_int;
            FB_MOD <= yp_mod;
            FB_FRAC <= yp_frac;
            DIV_LO <= yp_lo;
            DIV_HI <= yp_hi;
        end else begin
            if (WR_OUT_FB) begin
                FB_INT <= WR_FB_INT;
                FB_MOD <= WR_FB_MOD;
                FB_FRAC <= WR_FB_FRAC;
            end
            if (WR_OUT_DIV) begin
                DIV_LO <= WR_DIV_LO;
                DIV_HI <= WR_DIV_HI;
                DIV_2 <= WR_DIV_2;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            a_int_r <= IN_DIV_MIN;
            A_MOD <= PRESET_MOD_RESET;
            A_FRAC <= '0;
            a_sdm_r <= 1'b0;
        end else if (loading) begin
            a_int_r <= ap_int;
            A_MOD <= ap_mod;
            A_FRAC <= ap_frac;
            a_sdm_r <= 1'b1;
        end else if (WR_IN_A) begin
            a_int_r <= wr_in_int_c;
            A_MOD <= WR_IN_MOD;
            A_FRAC <= wr_in_frac_c;
            a_sdm_r <= WR_IN_SDM_EN;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            b_int_r <= IN_DIV_MIN;
            B_MOD <= PRESET_MOD_RESET;
            B_FRAC <= '0;
            b_sdm_r <= 1'b0;
        end else if (loading) begin
            b_int_r <= bp_int;
            B_MOD <= bp_mod;
            B_FRAC <= bp_frac;
            b_sdm_r <= 1'b1;
        end else if (WR_IN_B) begin
            b_int_r <= wr_in_int_c;
            B_MOD <= WR_IN_MOD;
            B_FRAC <= wr_in_frac_c;
            b_sdm_r <= WR_IN_SDM_EN;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            XTAL_SEL <= XTAL_49152;
            ratio_r <= RATIO_1;
            DITHER_ON <= 1'b1;
        end else if (WR_CFG) begin
            XTAL_SEL <= WR_XTAL_SEL;
            ratio_r <= (WR_RATIO_SEL == RATIO_2 || WR_RATIO_SEL == RATIO_4) ? WR_RATIO_SEL : RATIO_1;
            DITHER_ON <= !WR_DITHER_OFF;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            SLOW_MODE <= 1'b0;
            A_INT <= IN_DIV_MIN;
            B_INT <= IN_DIV_MIN;
            A_SDM_ON <= 1'b0;
            B_SDM_ON <= 1'b0;
        end else begin
            SLOW_MODE <= slow_w;
            A_INT <= a_eff;
            B_INT <= b_eff;
            A_SDM_ON <= a_sdm_r && !slow_w && (a_int_r >= SDM_MIN_INT);
            B_SDM_ON <= b_sdm_r && !slow_w && (b_int_r >= SDM_MIN_INT);
        end
    end

    // Integer dividers; pulses are clock enables counting system cycles as the reference model.
    logic [IW-1:0] a_cnt_r, b_cnt_r;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            a_cnt_r <= '0;
            b_cnt_r <= '0;
            A_DIV_PULSE <= 1'b0;
            B_DIV_PULSE <= 1'b0;
        end else begin
            A_DIV_PULSE <= (a_cnt_r + 6'h01 >= A_INT);
            B_DIV_PULSE <= (b_cnt_r + 6'h01 >= B_INT);
            a_cnt_r <= (a_cnt_r + 6'h01 >= A_INT) ? 6'h00 : a_cnt_r + 6'h01;
            b_cnt_r <= (b_cnt_r + 6'h01 >= B_INT) ? 6'h00 : b_cnt_r + 6'h01;
        end
    end

    // Sixteen-bit LFSR; it freezes when dithering is off so the modulator sees a constant.
    logic [15:0] lfsr_r;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            lfsr_r <= PRBS_SEED;
            DITHER_BIT <= 1'b0;
        end else begin
            if (DITHER_ON)
                lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
            DITHER_BIT <= DITHER_ON && lfsr_r[15];
        end
    end
endmodule // rpd_top
`default_nettype wire

// >>> testbench/rpd_checker.sv
`timescale 1ns/1ns
`default_nettype none
module rpd_checker (
    input wire logic CLK, // Clock
    input wire logic RESETN, // Reset, active low
    input wire logic [3:0] A_SEL, // First strap
    input wire logic [3:0] B_SEL, // Second strap
    input wire logic [3:0] Y_SEL, // Output strap
    input wire logic WR_OUT_FB, // Feedback write
    input wire logic [rpd_pkg::NW-1:0] WR_FB_INT, // Feedback integer in
    input wire logic WR_OUT_DIV, // Divider write
    input wire logic [rpd_pkg::PW-1:0] WR_DIV_2, // Second divider in
    input wire logic WR_CFG, // Mode write
    input wire logic [1:0] WR_XTAL_SEL, // Crystal code in
    input wire logic WR_DITHER_OFF, // Dither off in
    input wire logic SLOW_MODE, // Slow mode
    input wire logic [rpd_pkg::NW-1:0] FB_INT, // Feedback integer
    input wire logic [rpd_pkg::PW-1:0] DIV_LO, // Low divider
    input wire logic [rpd_pkg::PW-1:0] DIV_HI, // High divider
    input wire logic [rpd_pkg::PW-1:0] DIV_2, // Second divider
    input wire logic [1:0] XTAL_SEL, // Crystal code
    input wire logic [rpd_pkg::IW-1:0] A_INT, // First ratio
    input wire logic [rpd_pkg::MW-1:0] A_MOD, // First modulus
    input wire logic signed [rpd_pkg::FW-1:0] A_FRAC, // First fraction
    input wire logic A_SDM_ON, // First modulator on
    input wire logic B_SDM_ON, // Second modulator on
    input wire logic DITHER_ON, // Dither on
    input wire logic DITHER_BIT // Dither bit
);
    import rpd_pkg::*;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic run;
    logic [FW-1:0] a_mag;
    assign cnt_nxt = (cnt_r == 2'h3) ? cnt_r : cnt_r + 2'h1;
    assign run = cnt_r == 2'h3;
    assign a_mag = A_FRAC[FW-1] ? -A_FRAC : A_FRAC;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) cnt_r <= 2'h0;
        else cnt_r <= cnt_nxt;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // A three-cycle calm window leaves room for any synchroniser on the strap pins.
    sequence calm_straps;
        (run && $stable(A_SEL) && $stable(B_SEL))[*3];
    endsequence
    sequence slow_held;
        SLOW_MODE[*3];
    endsequence
    preset_load_a: assert property (cnt_r == 2'h1 |-> DIV_HI == DIV_HI_ONE && DIV_2 == SECOND_DIV_RESET
        && DIV_LO == (($past(Y_SEL) >= Y_FIRST_FIVE) ? DIV_LO_FIVE : DIV_LO_SIX)) else $error("preset load bad");
    fb_write_a: assert property (run && WR_OUT_FB |=> FB_INT == $past(WR_FB_INT)) else $error("fb write lost");
    div_write_a: assert property (run && WR_OUT_DIV |=> DIV_2 == $past(WR_DIV_2)) else $error("div write lost");
    div2_hold_a: assert property (run && !WR_OUT_DIV |=> $stable(DIV_2)) else $error("div2 moved");
    cfg_write_a: assert property (run && WR_CFG |=> XTAL_SEL == $past(WR_XTAL_SEL)
        && DITHER_ON == !$past(WR_DITHER_OFF)) else $error("cfg write lost");
    slow_detect_a: assert property (calm_straps |-> SLOW_MODE == (A_SEL == SEL_ALL_ONES || B_SEL == SEL_ALL_ONES))
        else $error("slow mode wrong");
    slow_sdm_off_a: assert property (slow_held |-> !A_SDM_ON && !B_SDM_ON) else $error("sdm on in slow");
    sdm_min_int_a: assert property (A_SDM_ON |-> A_INT >= SDM_MIN_INT) else $error("sdm int small");
    int_range_a: assert property (A_INT >= IN_DIV_MIN) else $error("ratio zero");
    frac_bound_a: assert property (run |-> a_mag < {1'b0, A_MOD}) else $error("fraction too big");
    dither_freeze_a: assert property ((!DITHER_ON)[*2] |=> $stable(DITHER_BIT)) else $error("dither moved");
endmodule // rpd_checker
bind rpd_top rpd_checker u_rpd_checker (.CLK(CLK), .RESETN(RESETN), .A_SEL(A_SEL), .B_SEL(B_SEL), .Y_SEL(Y_SEL),
    .WR_OUT_FB(WR_OUT_FB), .WR_FB_INT(WR_FB_INT), .WR_OUT_DIV(WR_OUT_DIV), .WR_DIV_2(WR_DIV_2), .WR_CFG(WR_CFG),
    .WR_XTAL_SEL(WR_XTAL_SEL), .WR_DITHER_OFF(WR_DITHER_OFF), .SLOW_MODE(SLOW_MODE), .FB_INT(FB_INT),
    .DIV_LO(DIV_LO), .DIV_HI(DIV_HI), .DIV_2(DIV_2), .XTAL_SEL(XTAL_SEL), .A_INT(A_INT), .A_MOD(A_MOD),
    .A_FRAC(A_FRAC), .A_SDM_ON(A_SDM_ON), .B_SDM_ON(B_SDM_ON), .DITHER_ON(DITHER_ON), .DITHER_BIT(DITHER_BIT));
`default_nettype wire

// >>> testbench/rpd_strap_model.sv
`timescale 1ns/1ns
`default_nettype none
module rpd_strap_model (
    input wire logic [3:0] a_gnd, // First strap pins grounded
    input wire logic [3:0] b_gnd, // Second strap pins grounded
    input wire logic [3:0] y_gnd, // Output strap pins grounded
    output logic [3:0] a_sel, // First strap level
    output logic [3:0] b_sel, // Second strap level
    output logic [3:0] y_sel // Output strap level
);
    // Open pins float high through board pull-ups, so an ungrounded pin reads one.
    assign a_sel = ~a_gnd;
    assign b_sel = ~b_gnd;
    assign y_sel = ~y_gnd;
endmodule // rpd_strap_model
`default_nettype wire

// >>> testbench/tb_rpd_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_rpd_top;
    import rpd_pkg::*;
    logic clk, resetn;
    logic [3:0] a_gnd, b_gnd, y_gnd, a_sel, b_sel, y_sel;
    logic [4:0] wr;
    logic [NW-1:0] wr_fb_int, fb_int;
    logic [MW-1:0] wr_fb_mod, wr_fb_frac, wr_in_mod, fb_mod, fb_frac, a_mod, b_mod;
    logic [PW-1:0] wr_div_lo, wr_div_hi, wr_div_2, div_lo, div_hi, div_2;
    logic [IW-1:0] wr_in_int, a_int, b_int;
    logic signed [FW-1:0] wr_in_frac, a_frac, b_frac;
    logic [1:0] wr_xtal, wr_ratio, xtal_sel;
    logic wr_sdm_en, wr_dither_off, slow_mode, a_sdm_on, b_sdm_on, a_pulse, b_pulse, dither_on, dither_bit;
    int err_count, n_compared;
    rpd_strap_model u_rpd_strap_model (.a_gnd(a_gnd), .b_gnd(b_gnd), .y_gnd(y_gnd), .a_sel(a_sel), .b_sel(b_sel),
        .y_sel(y_sel));
    rpd_top u_rpd_top (.CLK(clk), .RESETN(resetn), .A_SEL(a_sel), .B_SEL(b_sel), .Y_SEL(y_sel),
        .WR_OUT_FB(wr[0]), .WR_FB_INT(wr_fb_int), .WR_FB_MOD(wr_fb_mod), .WR_FB_FRAC(wr_fb_frac),
        .WR_OUT_DIV(wr[1]), .WR_DIV_LO(wr_div_lo), .WR_DIV_HI(wr_div_hi), .WR_DIV_2(wr_div_2),
        .WR_IN_A(wr[2]), .WR_IN_B(wr[3]), .WR_IN_INT(wr_in_int), .WR_IN_MOD(wr_in_mod), .WR_IN_FRAC(wr_in_frac),
        .WR_IN_SDM_EN(wr_sdm_en), .WR_CFG(wr[4]), .WR_XTAL_SEL(wr_xtal), .WR_RATIO_SEL(wr_ratio),
        .WR_DITHER_OFF(wr_dither_off), .SLOW_MODE(slow_mode), .FB_INT(fb_int), .FB_MOD(fb_mod), .FB_FRAC(fb_frac),
        .DIV_LO(div_lo), .DIV_HI(div_hi), .DIV_2(div_2), .XTAL_SEL(xtal_sel), .A_INT(a_int), .A_MOD(a_mod),
        .A_FRAC(a_frac), .A_SDM_ON(a_sdm_on), .B_INT(b_int), .B_MOD(b_mod), .B_FRAC(b_frac), .B_SDM_ON(b_sdm_on),
        .A_DIV_PULSE(a_pulse), .B_DIV_PULSE(b_pulse), .DITHER_ON(dither_on), .DITHER_BIT(dither_bit));
    always #50 clk = ~clk;
    task end_of_test;
        if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // Called right after a rising edge, so data and strobe change together on that edge.
    task go(input logic [4:0] m);
        wr <= m;
        @(posedge clk);
        wr <= 5'h00;
        settle(2);
    endtask
    task do_reset(input logic [3:0] a, input logic [3:0] b, input logic [3:0] y);
        @(posedge clk);
        resetn <= 1'b0;
        a_gnd <= ~a;
        b_gnd <= ~b;
        y_gnd <= ~y;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        settle(3);
    endtask
    task wr_in(input logic [IW-1:0] n, input logic [MW-1:0] m, input logic [FW-1:0] f, input logic e,
        input logic [4:0] w);
        @(posedge clk);
        wr_in_int <= n;
        wr_in_mod <= m;
        wr_in_frac <= f;
        wr_sdm_en <= e;
        go(w);
    endtask
    task wr_cfg(input logic [1:0] x, input logic off);
        @(posedge clk);
        wr_xtal <= x;
        wr_ratio <= x;
        wr_dither_off <= off;
        go(5'h10);
    endtask
    task t_presets;
        logic [3:0] yc[4] = '{4'h0, 4'hA, 4'hB, 4'hF};
        logic [31:0] en[4] = '{32'h8F, 32'h9B, 32'h85, 32'h95};
        logic [31:0] em[4] = '{32'h7EF40, 32'h77D80, 32'h503C0, 32'h7EF40};
        logic [31:0] ef[4] = '{32'h46B40, 32'h0DB80, 32'h1D0DD, 32'h445C0};
        for (int i = 0; i < 4; i++) begin
            do_reset(4'h0, 4'h1, yc[i]);
            chk("fb_int", en[i], fb_int);
            chk("fb_mod", em[i], fb_mod);
            chk("fb_frac", ef[i], fb_frac);
            chk("div_lo", (yc[i] >= 4'hB) ? 32'h5 : 32'h6, div_lo);
            chk("div_hi", 32'h1, div_hi);
            chk("div_2", 32'h1, div_2);
        end
        chk("a_int", 32'h17, a_int);
        chk("b_int", 32'h18, b_int);
        chk("a_mod", 32'h1FBD0, a_mod);
        chk("b_frac", 21'sh1E2B40, b_frac);
        chk("a_sdm", 32'h1, a_sdm_on);
        chk("slow", 32'h0, slow_mode);
        chk("dither_on", 32'h1, dither_on);
    endtask
    task t_override;
        @(posedge clk);
        wr_fb_int <= 8'hC8;
        wr_fb_mod <= 20'h12345;
        wr_fb_frac <= 20'h00ABC;
        go(5'h01);
        chk("fb_int", 32'hC8, fb_int);
        chk("fb_frac", 32'h00ABC, fb_frac);
        @(posedge clk);
        wr_div_2 <= 4'h3;
        wr_div_lo <= 4'h3;
        wr_div_hi <= 4'h2;
        wr <= 5'h02;
        @(posedge clk);
        wr_div_2 <= 4'h9;
        @(negedge clk);
        chk("div_2", 32'h3, div_2);
        @(posedge clk);
        wr <= 5'h00;
        settle(2);
        chk("div_2", 32'h9, div_2);
        chk("div_lo", 32'h3, div_lo);
        chk("div_hi", 32'h2, div_hi);
        chk("fb_mod", 32'h12345, fb_mod);
        do_reset(4'h0, 4'h1, 4'hF);
        chk("fb_int", 32'h95, fb_int);
        chk("div_2", 32'h1, div_2);
    endtask
    task t_slow;
        do_reset(4'hF, 4'h3, 4'h0);
        chk("slow", 32'h1, slow_mode);
        chk("a_sdm", 32'h0, a_sdm_on);
        chk("b_sdm", 32'h0, b_sdm_on);
        // Loop current is set by the host outside this block, so no port here can carry it.
        // Both references get one ratio since their rates must match.
        for (int x = 0; x < 4; x++) begin
            wr_cfg(x[1:0], 1'b0);
            chk("xtal", x, xtal_sel);
            chk("a_int", (x == 2) ? 32'h4 : (x == 1) ? 32'h2 : 32'h1, a_int);
            chk("b_int", (x == 2) ? 32'h4 : (x == 1) ? 32'h2 : 32'h1, b_int);
        end
        wr_in(6'h08, 20'h00010, 21'h000000, 1'b1, 5'h04);
        chk("a_sdm", 32'h0, a_sdm_on);
        @(posedge clk);
        wr_fb_int <= 8'h77;
        go(5'h01);
        chk("fb_int", 32'h77, fb_int);
        @(posedge clk);
        a_gnd <= 4'hF;
        b_gnd <= 4'h0;
        settle(4);
        chk("slow", 32'h1, slow_mode);
        @(posedge clk);
        b_gnd <= 4'hE;
        settle(4);
        chk("slow", 32'h0, slow_mode);
    endtask
    task t_indiv;
        logic [31:0] cnt, bcnt;
        wr_in(6'h3F, 20'h00010, 21'h1FFFF1, 1'b1, 5'h04);
        chk("a_int", 32'h3F, a_int);
        chk("a_sdm", 32'h1, a_sdm_on);
        chk("a_frac", 21'sh1FFFF1, a_frac);
        wr_in(6'h02, 20'h00010, 21'h000000, 1'b1, 5'h08);
        chk("b_int", 32'h4, b_int);
        chk("b_sdm", 32'h1, b_sdm_on);
        chk("b_mod", 32'h10, b_mod);
        wr_in(6'h05, 20'h00008, 21'h000008, 1'b1, 5'h04);
        chk("a_frac", 32'h7, a_frac);
        wr_in(6'h05, 20'h00008, 21'h1FFFF0, 1'b1, 5'h04);
        chk("a_frac", 21'sh1FFFF9, a_frac);
        wr_in(6'h00, 20'h00008, 21'h000000, 1'b0, 5'h04);
        chk("a_int", 32'h1, a_int);
        chk("a_sdm", 32'h0, a_sdm_on);
        wr_in(6'h05, 20'h00001, 21'h000000, 1'b0, 5'h04);
        cnt = 0;
        bcnt = 0;
        repeat (20) begin
            @(negedge clk);
            cnt += a_pulse;
            bcnt += b_pulse;
        end
        chk("a_pulses", 32'h4, cnt);
        chk("b_pulses", 32'h5, bcnt);
    endtask
    task t_dither;
        int ch;
        logic prev;
        for (int k = 0; k < 2; k++) begin
            if (k == 1) wr_cfg(2'h0, 1'b1);
            chk("dither_on", (k == 0) ? 32'h1 : 32'h0, dither_on);
            ch = 0;
            prev = dither_bit;
            repeat (16) begin
                @(negedge clk);
                ch += (dither_bit !== prev);
                prev = dither_bit;
            end
            chk("dither_moves", (k == 0) ? 32'h1 : 32'h0, ch != 0);
        end
        wr_cfg(2'h0, 1'b0);
        chk("dither_on", 32'h1, dither_on);
    endtask
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        a_gnd = 4'hF;
        b_gnd = 4'hE;
        y_gnd = 4'hF;
        {wr, wr_fb_int, wr_fb_mod, wr_fb_frac, wr_in_mod, wr_div_lo, wr_div_hi, wr_div_2} = '0;
        {wr_in_int, wr_in_frac, wr_xtal, wr_ratio, wr_sdm_en, wr_dither_off} = '0;
        t_presets;
        t_override;
        t_slow;
        t_indiv;
        t_dither;
        end_of_test;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        end_of_test;
    end
endmodule // tb_rpd_top
`default_nettype wire
